// [common/trig_route_pkg.sv]
package trig_route_pkg;
   localparam int          PIN_COUNT        = 10;
   localparam int          SIG_COUNT        = 13;
   localparam int          DED_COUNT        = 5;
   localparam int          SEL_W            = 4;
   localparam int          CNT_W            = 24;
   localparam int          CLK_PERIOD_PS    = 5000;
   // pulse windows in ns, as printed
   localparam int          PULSE_MIN_NS     = 50;
   localparam int          STROBE_MIN_NS    = 400;
   localparam int          SCAN_DELAY_MIN_NS = 50;
   localparam int          SLOW_CLK_NS      = 10000;
   localparam int          FAST_CLK_NS      = 1200;
   localparam int          STROBE_PULSES    = 8;
   localparam int          MIN_EDGE_NS      = 10;
   // least times round up to whole cycles
   localparam int          PULSE_CYC        = (PULSE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int          STROBE_CYC       = (STROBE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int          SCAN_DELAY_CYC   = (SCAN_DELAY_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // half period of each strobe burst clock
   localparam int          SLOW_HALF_CYC    = (SLOW_CLK_NS * 1000 / 2) / CLK_PERIOD_PS;
   localparam int          FAST_HALF_CYC    = (FAST_CLK_NS * 1000 / 2) / CLK_PERIOD_PS;
   localparam int          TMR_W            = 12;
   // signal indices into the routing table
   localparam int          SIG_START        = 0;
   localparam int          SIG_POST         = 1;
   // default output pins
   localparam int          PIN_START_OUT    = 0;
   localparam int          PIN_POST_OUT     = 1;
   typedef enum logic [1:0] {ACQ_IDLE, ACQ_PRE, ACQ_POST} acq_state_e;
endpackage

// [design/acq_trigger_pin_routing.sv]
// What this block does
// - ten two-way function pins; as outputs they mirror fixed internal timing signals
// - five dedicated output pins carry remaining timing signals
// - thirteen internal timing signals each pick their source pin in software
// - each function pin has its own driver enable, driving its fixed signal
// - each internal signal has polarity and edge or level detection on its selected pin
// - sample strobe starts 50-100 ns after conversion, lasts 400-500 ns
// - sample strobe is output only, software polarity and enable
// - single-pulse mode: latch strobe level follows software value
// - hardware mode: latch strobe bursts eight pulses from 10 us or 1.2 us clock
// - start trigger edge from any pin, either polarity, starts both acquisition kinds
// - start trigger output pulses high 50-100 ns, tri-stated after startup
// - start trigger defaults to pin 0, posttrigger reference to pin 1
// - software command can also start a pretriggered acquisition
// - posttrigger reference edge from any pin starts posttrigger phase
// - counter counts pretrigger scans, holds at zero until an accepted posttrigger edge reloads posttrigger count
// - posttrigger edge before counter reaches zero is ignored
// - after accepted posttrigger edge, exactly loaded scans then stop
// - posttrigger output pulses high 50-100 ns, unused posttriggered, tri-stated after startup
`timescale 1ns/10ps
`default_nettype none
module acq_trigger_pin_routing (
   input  wire logic                                    clk,
   input  wire logic                                    rst_n,
   input  wire logic [trig_route_pkg::PIN_COUNT-1:0]    pin_in,
   output logic      [trig_route_pkg::PIN_COUNT-1:0]    pin_out,
   output logic      [trig_route_pkg::PIN_COUNT-1:0]    pin_oe,
   input  wire logic [trig_route_pkg::PIN_COUNT-1:0]    pin_drive_en,
   input  wire logic [trig_route_pkg::PIN_COUNT-1:0]    fixed_sig,
   input  wire logic [trig_route_pkg::SIG_COUNT*trig_route_pkg::SEL_W-1:0] sig_src_sel,
   input  wire logic [trig_route_pkg::SIG_COUNT-1:0]    sig_invert,
   input  wire logic [trig_route_pkg::SIG_COUNT-1:0]    sig_edge_mode,
   output logic      [trig_route_pkg::SIG_COUNT-1:0]    sig_event,
   output logic      [trig_route_pkg::SIG_COUNT-1:0]    sig_level,
   input  wire logic [trig_route_pkg::DED_COUNT-1:0]    dedicated_sig,
   output logic      [trig_route_pkg::DED_COUNT-1:0]    dedicated_out,
   input  wire logic                                    conversion_start,
   input  wire logic                                    sample_strobe_en,
   input  wire logic                                    sample_strobe_invert,
   output logic                                         sample_taken_strobe,
   output logic                                         sample_taken_strobe_oe,
   input  wire logic                                    latch_hw_mode,
   input  wire logic                                    latch_level,
   input  wire logic                                    latch_fast_clk,
   input  wire logic                                    latch_burst_go,
   output logic                                         external_latch_strobe_n,
   output logic                                         latch_busy,
   input  wire logic                                    acq_arm,
   input  wire logic                                    acq_pretrig_mode,
   input  wire logic                                    sw_start,
   input  wire logic                                    start_from_pin,
   input  wire logic [trig_route_pkg::CNT_W-1:0]        pre_scans,
   input  wire logic [trig_route_pkg::CNT_W-1:0]        post_scans,
   input  wire logic                                    scan_done,
   output logic                                         acq_running,
   output logic                                         acq_post_phase,
   output logic      [trig_route_pkg::CNT_W-1:0]        scan_count,
   output logic                                         acquisition_start_trigger,
   output logic                                         posttrigger_reference
);
   import trig_route_pkg::*;

   logic [PIN_COUNT-1:0] pin_meta;
   logic [PIN_COUNT-1:0] pin_sync;
   logic                 start_evt;
   logic                 post_evt;
   logic                 post_accept;
   acq_state_e           state;
   logic                 start_fire;
   logic                 post_fire;
   logic                 start_pulse;
   logic                 post_pulse;
   logic                 strobe_pulse;
   logic [TMR_W-1:0]     scan_dly;
   logic                 scan_dly_run;
   logic [TMR_W-1:0]     burst_tmr;
   logic [4:0]           burst_half;
   logic                 burst_lvl;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchroniser, two flops before any logic
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta <= '0;
         pin_sync <= '0;
      end else begin
         pin_meta <= pin_in;
         pin_sync <= pin_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // input routing, one selector and detector per internal signal
   genvar g;
   generate
      for (g = 0; g < SIG_COUNT; g++) begin : g_route
         logic [SEL_W-1:0] sel;
         logic             lvl;
         logic             edg;
         logic             raw;
         assign sel = sig_src_sel[g*SEL_W +: SEL_W];
         // out-of-range select reads as low
         assign raw = (int'(sel) < PIN_COUNT) ? pin_sync[sel] : 1'b0;
         pin_edge_detect u_det (
            .clk       (clk),
            .rst_n     (rst_n),
            .level_in  (raw),
            .invert    (sig_invert[g]),
            .level_out (lvl),
            .edge_out  (edg)
         );
         assign sig_level[g] = lvl;
         assign sig_event[g] = sig_edge_mode[g] ? edg : lvl;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // pin outputs: fixed mirrors, trigger pins carry our own pulses
   always_comb begin
      pin_out = fixed_sig;
      pin_out[PIN_START_OUT] = start_pulse;
      pin_out[PIN_POST_OUT]  = post_pulse;
   end
   // enables default off, so pins float after startup; far side keeps off them when on
   assign pin_oe = pin_drive_en;
   assign dedicated_out = dedicated_sig;

   ////////////////////////////////////////////////////////////////////////////
   // acquisition sequencing
   assign start_evt  = (start_from_pin & g_route[SIG_START].edg) | sw_start;
   assign post_evt   = g_route[SIG_POST].edg;
   assign post_accept = (state == ACQ_PRE) && acq_pretrig_mode && (scan_count == '0) && post_evt;
   assign start_fire = (state == ACQ_IDLE) && acq_arm && start_evt;
   assign post_fire  = post_accept;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state      <= ACQ_IDLE;
         scan_count <= '0;
      end else begin
         case (state)
            ACQ_IDLE: begin
               if (start_fire) begin
                  if (acq_pretrig_mode) begin
                     state      <= ACQ_PRE;
                     scan_count <= pre_scans;
                  end else begin
                     state      <= ACQ_POST;
                     scan_count <= post_scans;
                  end
               end
            end
            ACQ_PRE: begin
               if (post_accept) begin
                  state      <= ACQ_POST;
                  scan_count <= post_scans;
               end else if (scan_done && scan_count != '0) begin
                  scan_count <= scan_count - 1'b1;
               end
            end
            ACQ_POST: begin
               if (scan_done) begin
                  scan_count <= scan_count - 1'b1;
                  if (scan_count <= CNT_W'(1)) begin
                     state      <= ACQ_IDLE;
                     scan_count <= '0;
                  end
               end
            end
            default: state <= ACQ_IDLE;
         endcase
      end
   end
   assign acq_running    = (state != ACQ_IDLE);
   assign acq_post_phase = (state == ACQ_POST);

   pulse_stretch #(.WIDTH_CYC(PULSE_CYC)) u_start_pulse (
      .clk   (clk),
      .rst_n (rst_n),
      .fire  (start_fire),
      .pulse (start_pulse)
   );
   pulse_stretch #(.WIDTH_CYC(PULSE_CYC)) u_post_pulse (
      .clk   (clk),
      .rst_n (rst_n),
      .fire  (post_fire),
      .pulse (post_pulse)
   );
   assign acquisition_start_trigger = start_pulse;
   assign posttrigger_reference     = post_pulse;

   ////////////////////////////////////////////////////////////////////////////
   // sample-taken strobe: delay then fixed-width pulse
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scan_dly     <= '0;
         scan_dly_run <= 1'b0;
      end else if (conversion_start) begin
         scan_dly     <= TMR_W'(SCAN_DELAY_CYC - 1);
         scan_dly_run <= 1'b1;
      end else if (scan_dly != '0) begin
         scan_dly <= scan_dly - 1'b1;
      end else begin
         scan_dly_run <= 1'b0;
      end
   end
   pulse_stretch #(.WIDTH_CYC(STROBE_CYC)) u_strobe (
      .clk   (clk),
      .rst_n (rst_n),
      .fire  (scan_dly_run && scan_dly == '0),
      .pulse (strobe_pulse)
   );
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sample_taken_strobe <= 1'b0;
      end else begin
         sample_taken_strobe <= strobe_pulse ^ sample_strobe_invert;
      end
   end
   assign sample_taken_strobe_oe = sample_strobe_en;

   ////////////////////////////////////////////////////////////////////////////
   // external latch strobe, active low; burst is eight low pulses
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         burst_tmr  <= '0;
         burst_half <= '0;
         burst_lvl  <= 1'b1;
      end else if (!latch_hw_mode) begin
         burst_half <= '0;
         burst_lvl  <= 1'b1;
      end else if (burst_half == '0) begin
         if (latch_burst_go) begin
            burst_half <= 5'(2 * STROBE_PULSES);
            burst_lvl  <= 1'b0;
            burst_tmr  <= latch_fast_clk ? TMR_W'(FAST_HALF_CYC - 1) : TMR_W'(SLOW_HALF_CYC - 1);
         end
      end else if (burst_tmr != '0) begin
         burst_tmr <= burst_tmr - 1'b1;
      end else begin
         burst_half <= burst_half - 1'b1;
         // last toggle parks the line high, else a ninth low would hang on
         burst_lvl  <= (burst_half == 5'h01) | ~burst_lvl;
         burst_tmr  <= latch_fast_clk ? TMR_W'(FAST_HALF_CYC - 1) : TMR_W'(SLOW_HALF_CYC - 1);
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         external_latch_strobe_n <= 1'b1;
      end else begin
         external_latch_strobe_n <= latch_hw_mode ? burst_lvl : latch_level;
      end
   end
   assign latch_busy = (burst_half != '0);

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb_chk @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   // run length of the start pulse; a counter keeps the width check short
   logic [TMR_W-1:0] start_run;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         start_run <= '0;
      end else if (start_pulse) begin
         start_run <= start_run + 1'b1;
      end else begin
         start_run <= '0;
      end
   end

   property p_post_ignored_early;
      (state == ACQ_PRE && scan_count != '0) |=> state != ACQ_POST;
   endproperty
   a_post_ignored_early: assert property (p_post_ignored_early)
      else $error("posttrigger accepted before count reached zero");
   property p_start_width;
      start_fire |=> ##9 (start_pulse && start_run == TMR_W'(PULSE_CYC - 1)) ##1 !start_pulse;
   endproperty
   a_start_width: assert property (p_start_width)
      else $error("start trigger pulse width wrong");
   property p_post_width;
      post_fire |=> post_pulse [*8];
   endproperty
   a_post_width: assert property (p_post_width)
      else $error("posttrigger pulse too short");
   property p_post_reload;
      post_accept |=> (state == ACQ_POST && scan_count == $past(post_scans));
   endproperty
   a_post_reload: assert property (p_post_reload)
      else $error("posttrigger count not loaded");
   property p_strobe_delay;
      conversion_start |=> !strobe_pulse [*8];
   endproperty
   a_strobe_delay: assert property (p_strobe_delay)
      else $error("sample strobe too early");
   property p_strobe_rise;
      (conversion_start && !strobe_pulse) |-> ##[10:12] strobe_pulse;
   endproperty
   a_strobe_rise: assert property (p_strobe_rise)
      else $error("sample strobe late");
   property p_latch_sw;
      (!latch_hw_mode && !$past(latch_hw_mode)) |=> external_latch_strobe_n == $past(latch_level);
   endproperty
   a_latch_sw: assert property (p_latch_sw)
      else $error("latch strobe not following level");
   property p_stop;
      (state == ACQ_POST && scan_done && scan_count == CNT_W'(1)) |=> state == ACQ_IDLE;
   endproperty
   a_stop: assert property (p_stop)
      else $error("acquisition did not stop");
   property p_sw_start;
      (state == ACQ_IDLE && acq_arm && sw_start) |=> acq_running;
   endproperty
   a_sw_start: assert property (p_sw_start)
      else $error("software start ignored");
   c_pretrig: cover property (post_accept);
   c_posttrig: cover property (start_fire && !acq_pretrig_mode);
   c_early_post: cover property (state == ACQ_PRE && scan_count != '0 && post_evt);
   c_burst: cover property (latch_busy ##1 !latch_busy);
   c_strobe: cover property ($rose(strobe_pulse));
endmodule
`default_nettype wire

// [design/pin_edge_detect.sv]
`timescale 1ns/10ps
`default_nettype none
module pin_edge_detect (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic level_in,
   input  wire logic invert,
   output logic      level_out,
   output logic      edge_out
);
   logic prev;

   // level_in is already synchronised; invert first so both polarities share one rising detector
   assign level_out = level_in ^ invert;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev <= 1'b0;
      end else begin
         prev <= level_out;
      end
   end
   assign edge_out = level_out & ~prev;
endmodule
`default_nettype wire

// [design/pulse_stretch.sv]
`timescale 1ns/10ps
`default_nettype none
module pulse_stretch #(
   parameter int WIDTH_CYC = 10
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic fire,
   output logic      pulse
);
   logic [11:0] cnt;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt   <= 12'h000;
         pulse <= 1'b0;
      end else if (fire) begin
         cnt   <= 12'(WIDTH_CYC - 1);
         pulse <= 1'b1;
      end else if (cnt != 12'h000) begin
         cnt <= cnt - 12'h001;
      end else begin
         pulse <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// [sim/acq_trigger_pin_routing_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module acq_trigger_pin_routing_bench;
   import trig_route_pkg::*;
   typedef struct {int kind; int lo; int hi;} note_s;
   logic                       clk = 1'b0;
   logic                       rst_n = 1'b0;
   logic [PIN_COUNT-1:0]       pin_in, pin_out, pin_oe, pin_drive_en, fixed_sig, idle_lvl;
   logic [SIG_COUNT*SEL_W-1:0] sig_src_sel;
   logic [SIG_COUNT-1:0]       sig_invert, sig_edge_mode, sig_event, sig_level;
   logic [DED_COUNT-1:0]       dedicated_sig, dedicated_out;
   logic                       conversion_start, sample_strobe_en, sample_strobe_invert, sample_taken_strobe;
   logic                       sample_taken_strobe_oe, latch_hw_mode, latch_level, latch_fast_clk;
   logic                       latch_burst_go, external_latch_strobe_n, latch_busy, acq_arm, acq_pretrig_mode;
   logic                       sw_start, start_from_pin, scan_done, acq_running, acq_post_phase;
   logic                       acquisition_start_trigger, posttrigger_reference, ext_fire, watch_strobe, inv, quiet;
   logic [CNT_W-1:0]           pre_scans, post_scans, scan_count;
   logic [3:0]                 ext_sel;
   logic [7:0]                 ext_width;
   logic [5:0]                 mon;
   logic [31:0]                seed = 32'h00005b6e;
   note_s                      notes[$];
   int                         wid[6] = '{default: 0};
   int                         bad_count = 0;
   int                         compares = 0;
   int                         p, n, h, d;

   always #2.5 clk = ~clk;
   acq_trigger_pin_routing i_acq_trigger_pin_routing (.*);
   ext_pins i_ext_pins (.clk(clk), .pin_oe(pin_oe), .pin_out(pin_out), .idle_lvl(idle_lvl),
                        .fire(ext_fire), .sel(ext_sel), .width(ext_width), .pin_in(pin_in));
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
   endtask
   task automatic print_verdict();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic check_pulse(input int kind, input int w);
      note_s nt;
      compares++;
      if (notes.size() == 0) begin
         bad_count++;
         $display("BAD %0t stray pulse kind %0d width %0d", $time, kind, w);
      end else begin
         nt = notes.pop_front();
         if (nt.kind != kind || w < nt.lo || w > nt.hi) begin
            bad_count++;
            $display("BAD %0t pulse kind %0d width %0d, noted kind %0d", $time, kind, w, nt.kind);
         end
      end
   endtask
   task automatic guard(input logic ok, input string what);
      if (!ok) begin
         bad_count++;
         $display("BAD %0t timeout %s", $time, what);
         print_verdict();
      end
   endtask
   task automatic note(input int kind, input int lo, input int hi);
      notes.push_back('{kind, lo, hi});
   endtask
   task automatic end_test(input string name);
      @(negedge clk);
      check_val(notes.size() == 0, 1'b1, "pulses missing");
      $display("test %s done, bad_count %0d", name, bad_count);
   endtask
   // a polarity flip is a real edge inside the block, so events are masked while retuning
   task automatic route(input int s, input int pin, input logic pol);
      @(posedge clk);
      quiet <= 1'b1;
      sig_src_sel[s*4 +: 4] <= 4'hf;
      sig_invert[s] <= pol;
      idle_lvl[pin] <= pol;
      tick(5);
      sig_src_sel[s*4 +: 4] <= 4'(pin);
      tick(5);
      quiet <= 1'b0;
   endtask
   task automatic pin_pulse(input int pin, input int w);
      @(posedge clk);
      ext_sel <= 4'(pin);
      ext_width <= 8'(w);
      ext_fire <= 1'b1;
      @(posedge clk);
      ext_fire <= 1'b0;
   endtask
   task automatic scans(input int k);
      repeat (k) begin
         @(posedge clk);
         scan_done <= 1'b1;
         @(posedge clk);
         scan_done <= 1'b0;
         tick(2);
      end
      @(negedge clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // 0 sig0 event, 1 sig1 event, 2 start, 3 posttrigger, 4 sample strobe, 5 latch low
   assign mon = {latch_hw_mode & ~external_latch_strobe_n, watch_strobe & (sample_taken_strobe ^ sample_strobe_invert),
                 posttrigger_reference, acquisition_start_trigger, sig_event[1:0] & ~{2{quiet}}};
   always @(posedge clk) begin
      for (int k = 0; k < 6; k++) begin
         if (rst_n && mon[k]) begin
            wid[k]++;
         end else if (wid[k] != 0) begin
            check_pulse(k, wid[k]);
            wid[k] = 0;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {pin_drive_en, fixed_sig, idle_lvl, sig_invert, dedicated_sig} = '0;
      sig_src_sel = '1;
      sig_edge_mode = 13'h1ffb;
      {conversion_start, sample_strobe_en, sample_strobe_invert, latch_hw_mode, latch_fast_clk} = '0;
      {latch_burst_go, acq_arm, acq_pretrig_mode, sw_start, start_from_pin, scan_done} = '0;
      {quiet, ext_fire, watch_strobe, ext_sel, ext_width, pre_scans, post_scans} = '0;
      latch_level = 1'b1;
      tick(3);
      rst_n <= 1'b1;
      @(negedge clk);
      check_val({acquisition_start_trigger, posttrigger_reference, pin_oe}, '0, "outputs off");
      check_val({external_latch_strobe_n, acq_running, scan_count}, 32'h02000000, "idle");
      @(posedge clk);
      pin_drive_en <= 10'(rnd());
      fixed_sig <= 10'(rnd());
      dedicated_sig <= 5'(rnd());
      @(negedge clk);
      check_val(pin_oe, pin_drive_en, "pin enables");
      check_val(pin_out[9:2], fixed_sig[9:2], "mirrored pins");
      check_val(dedicated_out, dedicated_sig, "dedicated pins");
      @(posedge clk);
      pin_drive_en <= '0;
      end_test("pins");
      for (int t = 0; t < 4; t++) begin
         p = rnd() % 5;
         route(0, p, t[0]);
         route(2, p, t[0]);
         note(0, 1, 1);
         pin_pulse(p, 4 + t);
         tick(2);
         @(negedge clk);
         check_val({sig_level[2], sig_event[2]}, 2'b11, "level route");
         tick(10);
      end
      end_test("edges");
      inv = 1'(rnd());
      route(0, 3, inv);
      n = 2 + rnd() % 4;
      @(posedge clk);
      {acq_arm, start_from_pin, pin_drive_en} <= {2'b11, 10'h003};
      post_scans <= 24'(n);
      note(0, 1, 1);
      note(2, PULSE_CYC, 2 * PULSE_CYC);
      pin_pulse(3, 3);
      for (d = 0; d < 20; d++) begin
         @(negedge clk);
         if (acquisition_start_trigger) break;
      end
      guard(acquisition_start_trigger, "start pulse");
      check_val(pin_out[0], 1'b1, "start on pin 0");
      @(posedge clk);
      sw_start <= 1'b1;
      @(posedge clk);
      sw_start <= 1'b0;
      tick(12);
      @(negedge clk);
      check_val(scan_count, 24'(n), "post count");
      scans(n - 1);
      check_val(acq_running, 1'b1, "still running");
      scans(1);
      check_val(acq_running, 1'b0, "stopped");
      {acq_arm, start_from_pin, pin_drive_en} <= '0;
      end_test("posttriggered");
      route(1, 6, 1'(rnd()));
      @(posedge clk);
      {acq_arm, acq_pretrig_mode, sw_start} <= 3'b111;
      pre_scans <= 24'h000003;
      post_scans <= 24'h000002;
      note(2, PULSE_CYC, 2 * PULSE_CYC);
      @(posedge clk);
      sw_start <= 1'b0;
      tick(14);
      @(negedge clk);
      check_val({acq_running, acq_post_phase, scan_count}, 32'h02000003, "pre phase");
      note(1, 1, 1);
      pin_pulse(6, 3);
      tick(10);
      @(negedge clk);
      check_val(acq_post_phase, 1'b0, "early edge");
      scans(3);
      check_val({acq_running, scan_count}, 25'h1000000, "count at zero");
      note(1, 1, 1);
      note(3, PULSE_CYC, 2 * PULSE_CYC);
      pin_pulse(6, 3);
      tick(6);
      @(negedge clk);
      check_val({pin_out[1], acq_post_phase, scan_count}, 26'h3000002, "post phase");
      scans(1);
      check_val(acq_running, 1'b1, "post running");
      scans(1);
      check_val(acq_running, 1'b0, "post stopped");
      acq_arm <= 1'b0;
      end_test("pretriggered");
      for (int s = 0; s < 2; s++) begin
         @(posedge clk);
         sample_strobe_invert <= s[0];
         sample_strobe_en <= 1'b1;
         tick(3);
         @(negedge clk);
         check_val({sample_taken_strobe_oe, sample_taken_strobe}, {1'b1, s[0]}, "strobe idle");
         watch_strobe = 1'b1;
         note(4, 80, 100);
         @(posedge clk);
         conversion_start <= 1'b1;
         @(posedge clk);
         conversion_start <= 1'b0;
         for (d = 1; d < 40; d++) begin
            @(negedge clk);
            if (mon[4]) break;
         end
         check_val(d >= 10 && d <= 20, 1'b1, "strobe delay");
         tick(110);
         @(negedge clk);
         watch_strobe = 1'b0;
      end
      sample_strobe_en <= 1'b0;
      tick(2);
      check_val(sample_taken_strobe_oe, 1'b0, "strobe oe off");
      end_test("sample strobe");
      for (int m = 0; m < 2; m++) begin
         @(posedge clk);
         latch_level <= m[0];
         tick(3);
         @(negedge clk);
         check_val(external_latch_strobe_n, m[0], "latch level");
      end
      for (int f = 0; f < 2; f++) begin
         h = f ? FAST_HALF_CYC : SLOW_HALF_CYC;
         repeat (8) note(5, h - 1, h + 1);
         @(posedge clk);
         latch_hw_mode <= 1'b1;
         latch_fast_clk <= f[0];
         @(posedge clk);
         latch_burst_go <= 1'b1;
         @(posedge clk);
         latch_burst_go <= 1'b0;
         for (d = 0; d < 20 * h; d++) begin
            @(negedge clk);
            if (!latch_busy && d > 2) break;
         end
         guard(!latch_busy, "latch burst");
         tick(4);
         latch_hw_mode <= 1'b0;
         end_test("latch burst");
      end
      print_verdict();
   end
endmodule
`default_nettype wire

// [sim/ext_pins.sv]
`timescale 1ns/10ps
`default_nettype none
module ext_pins (
   input  wire logic       clk,
   input  wire logic [9:0] pin_oe,
   input  wire logic [9:0] pin_out,
   input  wire logic [9:0] idle_lvl,
   input  wire logic       fire,
   input  wire logic [3:0] sel,
   input  wire logic [7:0] width,
   output logic      [9:0] pin_in
);
   logic [9:0] ext_lvl;
   int         left = 0;
   ////////////////////////////////////////////////////////////////////////////
   // anything under 10 ns is stretched to two cycles
   always @(posedge clk) begin
      if (fire) begin
         left <= (width < 8'h02) ? 2 : int'(width);
      end else if (left != 0) begin
         left <= left - 1;
      end
   end
   always_comb begin
      ext_lvl = idle_lvl;
      if (left != 0 && sel < 4'ha) begin
         ext_lvl[sel] = ~idle_lvl[sel];
      end
   end
   // backs off any pin whose driver the device has on
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule
`default_nettype wire
